// ==== tone_volume_cfg.svh ====
// Purpose: Constants for the serial tone and volume command decoder.
// Assumes: Codes are the raw bit patterns carried on the serial link.
// Notes:   Definitions only; included by its bare name.
`ifndef TONE_VOLUME_CFG_SVH
`define TONE_VOLUME_CFG_SVH

// Device selection address and word layout.
`define DEV_ADDR      2'h2
`define ADDR_BITS     2
`define WORD_BITS     9
`define SET_BITS      6

// Function selector codes.
`define FN_INPUT      3'h0
`define FN_BASS       3'h1
`define FN_TREBLE     3'h2
`define FN_VOLUME     3'h3
`define FN_FADER_BASE 3'h4

// Top codes; a larger volume, fader or tone code is held at the top step, a larger input code with bit three clear falls back to open.
`define VOL_MAX       6'h28
`define FADER_MAX     6'h14
`define TONE_MAX      6'h0C
`define INPUT_MAX     3'h4

// Power-up values: minimum level, flat tone, open input.
`define VOL_RST       6'h00
`define FADER_RST     5'h00
`define TONE_FLAT     4'h6
`define INPUT_RST     3'h0

// Synchroniser depth for link pins.
`define SYNC_STAGES   3

`endif

// ==== tone_volume_pkg.sv ====
// Purpose: Types shared by the serial tone and volume decoder.
// Assumes: Nothing beyond the configuration header.
// Notes:   Only types live here; numbers stay in the header.
package tone_volume_pkg;

    // Link receiver states within one enable frame.
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ADDR,
        ST_BODY,
        ST_SKIP
    } link_state_t;

endpackage

// ==== pin_filter.sv ====
// Purpose: Three-stage synchroniser with agreement filter for link pins.
// Assumes: Inputs are asynchronous to clk_sys.
// Notes:   A change counts once stages two and three agree.
`timescale 1ns/100ps

module pin_filter #(
    parameter int WIDTH = 3
) (
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] raw,
    output logic      [WIDTH-1:0] level_r,
    output logic      [WIDTH-1:0] rise_r,
    output logic      [WIDTH-1:0] fall_r
);

    logic [WIDTH-1:0] s1_r;
    logic [WIDTH-1:0] s2_r;
    logic [WIDTH-1:0] s3_r;
    logic [WIDTH-1:0] agree;

    // The first stage feeds only the second, so metastability stays put.
    // Stages and level reset high, the idle level of the enable pin, so no
    // false enable rise follows reset; a pin idling low only shows a fall.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= '1;
            s2_r <= '1;
            s3_r <= '1;
        end else begin
            s1_r <= raw;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    assign agree = ~(s2_r ^ s3_r);

    // Level follows only agreed values; edges pulse for one cycle.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            level_r <= '1;
            rise_r  <= '0;
            fall_r  <= '0;
        end else begin
            level_r <= (agree & s3_r) | (~agree & level_r);
            rise_r  <= agree & s3_r & ~level_r;
            fall_r  <= agree & ~s3_r & level_r;
        end
    end

endmodule

// ==== tone_volume_serial_decoder.sv ====
// Purpose: Decodes three-wire serial commands into audio control settings.
// Assumes: Link pins are asynchronous and slow against clk_sys (50 MHz).
// Notes:   All outputs are registers; settings change only on a commit.
`timescale 1ns/100ps
`include "tone_volume_cfg.svh"

// Operation
// RQ1 - First two bits of a frame are the device address; must equal 10.
// RQ2 - Nine-bit word splits into three selector bits and six setting bits.
// RQ3 - Selector picks rear/front faders, volume, treble, bass or input.
// RQ4 - Volume uses six bits, 0 to 40 steps; 10100X is top.
// RQ5 - Fader ignores top bit, 0 to 20 steps; X1010X is top.
// RQ6 - Tone ignores top two bits; 0 cut, 6 flat, 12 boost.
// RQ7 - Input ignores top two bits, needs zero next; open or inputs 1-4.
// RQ8 - One code step equals one 2 dB level step.
// RQ9 - Controller always sends all six setting bits.
// RQ10 - Controller sends only listed setting codes.
// RQ11 - Any number of bits may follow the address; last nine count.
// RQ12 - Data sampled on each rising serial clock edge.
// RQ13 - Only last nine bits used; wrong address ignores the transfer.
// RQ14 - Enable rising stops shifting and latches settings; only then change.
// RQ15 - Controller drops enable only while serial clock is low.
// RQ16 - After reset volume and faders minimum, tone flat.
// RQ17 - Bits arrive most significant first.
module tone_volume_serial_decoder (
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic       ser_clk,
    input  wire logic       ser_data,
    input  wire logic       ser_enable,
    output logic      [5:0] volume_level_r,
    output logic      [4:0] fader_rf_r,
    output logic      [4:0] fader_lf_r,
    output logic      [4:0] fader_rr_r,
    output logic      [4:0] fader_lr_r,
    output logic      [3:0] treble_level_r,
    output logic      [3:0] bass_level_r,
    output logic      [2:0] input_sel_r,
    output logic            cmd_strobe_r
);

    tone_volume_pkg::link_state_t state_r;
    logic [2:0]                   lvl;
    logic [2:0]                   rise;
    logic [2:0]                   fall;
    logic                         data_bit;
    logic                         clk_rise;
    logic                         en_rise;
    logic                         en_level;
    logic                         addr_first_r;
    logic                         addr_cnt_r;
    logic [3:0]                   body_cnt_r;
    logic [8:0]                   shift_r;
    logic                         commit;
    logic [2:0]                   function_selector_bits;
    logic [5:0]                   setting;
    logic [5:0]                   vol_nxt;
    logic [5:0]                   fad_nxt;
    logic [5:0]                   tone_nxt;
    logic [4:0]                   fader_r [4];
    logic                         cmd_seen_r;

    // Pick the smaller of a code and its top step.
    function automatic logic [5:0] clamp(input logic [5:0] code,
                                         input logic [5:0] top);
        clamp = (code > top) ? top : code;
    endfunction

    // Data, clock and enable share one pipeline so they stay aligned.
    pin_filter #(
        .WIDTH (3)
    ) u_pins (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .raw     ({ser_enable, ser_clk, ser_data}),
        .level_r (lvl),
        .rise_r  (rise),
        .fall_r  ()
    );

    assign data_bit = lvl[0];
    assign clk_rise = rise[1];
    assign en_rise  = rise[2];
    assign en_level = lvl[2];

    // Frame state: address phase, then accept or skip until enable rises.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= tone_volume_pkg::ST_IDLE;
        end else begin
            case (state_r)
                tone_volume_pkg::ST_IDLE: begin
                    if (!en_level)
                        state_r <= tone_volume_pkg::ST_ADDR;
                end
                tone_volume_pkg::ST_ADDR: begin
                    if (en_rise)
                        state_r <= tone_volume_pkg::ST_IDLE;
                    else if (clk_rise && addr_cnt_r) begin
                        // Wrong address skips the whole frame. [RQ1] [RQ13]
                        if ({addr_first_r, data_bit} == `DEV_ADDR)
                            state_r <= tone_volume_pkg::ST_BODY;
                        else
                            state_r <= tone_volume_pkg::ST_SKIP;
                    end
                end
                tone_volume_pkg::ST_BODY,
                tone_volume_pkg::ST_SKIP: begin
                    if (en_rise)
                        state_r <= tone_volume_pkg::ST_IDLE; // [RQ14]
                end
                default: begin
                    state_r <= tone_volume_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Address bits arrive first, high bit leading. [RQ17]
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            addr_cnt_r   <= 1'b0;
            addr_first_r <= 1'b0;
        end else if (state_r == tone_volume_pkg::ST_IDLE) begin
            addr_cnt_r   <= 1'b0;
        end else if (state_r == tone_volume_pkg::ST_ADDR && clk_rise
                     && !en_rise) begin
            addr_cnt_r   <= 1'b1;
            addr_first_r <= data_bit;
        end
    end

    // Shift on each clock rise; older bits fall off the top, so any
    // number of extra bits leaves only the last nine. [RQ11] [RQ12] [RQ13]
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            shift_r    <= '0;
            body_cnt_r <= '0;
        end else if (state_r == tone_volume_pkg::ST_ADDR) begin
            body_cnt_r <= '0;
        end else if (state_r == tone_volume_pkg::ST_BODY && clk_rise
                     && !en_rise) begin
            shift_r <= {shift_r[7:0], data_bit}; // [RQ17]
            if (body_cnt_r != 4'(`WORD_BITS))
                body_cnt_r <= body_cnt_r + 4'h1;
        end
    end

    // A frame commits only with a matched address and a full word.
    assign commit = (state_r == tone_volume_pkg::ST_BODY) && en_rise
                    && (body_cnt_r == 4'(`WORD_BITS)); // [RQ14]

    // Split the word and clamp each field to its top step. [RQ2] [RQ8]
    always_comb begin
        function_selector_bits = shift_r[8:6];
        setting  = shift_r[5:0];
        vol_nxt  = clamp(setting, `VOL_MAX); // [RQ4]
        fad_nxt  = clamp({1'b0, setting[4:0]}, `FADER_MAX); // [RQ5]
        tone_nxt = clamp({2'b00, setting[3:0]}, `TONE_MAX); // [RQ6]
    end

    // Volume and tone latches; reset gives minimum and flat. [RQ16]
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            volume_level_r <= `VOL_RST;
            treble_level_r <= `TONE_FLAT;
            bass_level_r   <= `TONE_FLAT;
        end else if (commit) begin
            case (function_selector_bits) // [RQ3]
                `FN_VOLUME: volume_level_r <= vol_nxt;
                `FN_TREBLE: treble_level_r <= tone_nxt[3:0];
                `FN_BASS:   bass_level_r   <= tone_nxt[3:0];
                default: begin
                end
            endcase
        end
    end

    // Input select; a set bit three is not a listed code and is dropped.
    // Low codes above four fall back to open rather than guess. [RQ7]
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            input_sel_r <= `INPUT_RST;
        end else if (commit && function_selector_bits == `FN_INPUT
                     && !setting[3]) begin
            input_sel_r <= (setting[2:0] > `INPUT_MAX) ? `INPUT_RST
                                                       : setting[2:0];
        end
    end

    // Four faders share one shape; selector codes 100 to 111. [RQ3] [RQ5]
    for (genvar i = 0; i < 4; i++) begin : g_fader
        always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n)
                fader_r[i] <= `FADER_RST; // [RQ16]
            else if (commit
                     && function_selector_bits == `FN_FADER_BASE + 3'(i))
                fader_r[i] <= fad_nxt[4:0];
        end
    end

    assign fader_rf_r = fader_r[0];
    assign fader_lf_r = fader_r[1];
    assign fader_rr_r = fader_r[2];
    assign fader_lr_r = fader_r[3];

    // One-cycle strobe after every accepted command.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            cmd_strobe_r <= 1'b0;
        else
            cmd_strobe_r <= commit;
    end

    // Helper for checking: set once any command has been accepted.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            cmd_seen_r <= 1'b0;
        else if (commit)
            cmd_seen_r <= 1'b1;
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    addr_skip_a: assert property ( // [RQ13]
        (state_r == tone_volume_pkg::ST_SKIP && en_rise)
        |=> !cmd_strobe_r && $stable(volume_level_r) && $stable(input_sel_r))
        else $error("Foreign address changed a setting.");

    addr_match_a: assert property ( // [RQ1]
        (state_r == tone_volume_pkg::ST_ADDR && clk_rise && addr_cnt_r
         && !en_rise && {addr_first_r, data_bit} == 2'h2)
        |=> state_r == tone_volume_pkg::ST_BODY)
        else $error("Own address not accepted.");

    volume_load_a: assert property ( // [RQ4]
        (commit && shift_r[8:6] == 3'h3)
        |=> volume_level_r == (($past(shift_r[5:0]) > 6'h28) ? 6'h28
                               : $past(shift_r[5:0])))
        else $error("Volume code not loaded as sent.");

    fader_range_a: assert property ( // [RQ5]
        fader_lr_r <= 5'h14 && fader_rf_r <= 5'h14)
        else $error("Fader beyond top step.");

    tone_range_a: assert property ( // [RQ6]
        treble_level_r <= 4'hC && bass_level_r <= 4'hC)
        else $error("Tone beyond top step.");

    input_guard_a: assert property ( // [RQ7]
        (commit && shift_r[8:6] == 3'h0 && shift_r[3])
        |=> $stable(input_sel_r))
        else $error("Input changed on a code with bit three set.");

    shift_sample_a: assert property ( // [RQ12]
        (state_r == tone_volume_pkg::ST_BODY && clk_rise && !en_rise)
        |=> shift_r[0] == $past(data_bit)
            && shift_r[8:1] == $past(shift_r[7:0]))
        else $error("Serial bit not shifted in.");

    latch_only_a: assert property ( // [RQ14]
        !commit |=> $stable(volume_level_r) && $stable(treble_level_r)
                    && $stable(bass_level_r) && $stable(fader_lf_r))
        else $error("Setting changed without a commit.");

    idle_hold_a: assert property ( // [RQ14]
        state_r == tone_volume_pkg::ST_IDLE |=> $stable(shift_r))
        else $error("Shift register moved while enable high.");

    strobe_pulse_a: assert property ( // [RQ14]
        commit |=> cmd_strobe_r ##1 !cmd_strobe_r)
        else $error("Command strobe not a single pulse.");

    power_up_a: assert property ( // [RQ16]
        !cmd_seen_r |-> volume_level_r == 6'h00 && treble_level_r == 4'h6
                        && bass_level_r == 4'h6 && fader_rr_r == 5'h00)
        else $error("Power-up values disturbed.");

    body_count_a: assert property ( // [RQ11]
        body_cnt_r <= 4'h9)
        else $error("Word counter overran.");

    vol_cmd_c: cover property (commit && shift_r[8:6] == 3'h3);
    fader_cmd_c: cover property (commit && shift_r[8]
                                 && setting[4:0] == 5'h15);
    skip_frame_c: cover property (state_r == tone_volume_pkg::ST_SKIP
                                  && en_rise);
    input_cmd_c: cover property (commit && shift_r[8:6] == 3'h0);

endmodule

// ==== serial_ctl_model.sv ====
// Purpose: Behavioural controller that drives the three-wire serial link.
// Assumes: The link idles with enable high and the serial clock low.
// Notes:   Edges land 1 ns after a clk_sys rise; send stops the clock between
//          frames, as a real controller's shifter does; stray pulses it with enable high.
`timescale 1ns/100ps

module serial_ctl_model (
    input  wire logic clk_sys,
    output logic      ser_clk,
    output logic      ser_data,
    output logic      ser_enable
);
    // Idle levels; the data line is driven high at the start.
    initial begin
        ser_clk    = 1'b0;
        ser_data   = 1'b1;
        ser_enable = 1'b1;
    end

    // Sends the low n bits of f, top bit first, h clk_sys cycles per half.
    task automatic send(input logic [23:0] f, input int n, input int h);
        @(posedge clk_sys);
        #1;
        ser_enable = 1'b0; // Enable falls while the clock is low.
        for (int i = n - 1; i >= 0; i--) begin // All bits go out.
            ser_data = f[i];
            #(20 * h) ser_clk = 1'b1; // Bit stands across the rise.
            #(20 * h) ser_clk = 1'b0;
        end
        // Hold time is over, so the old value must not linger.
        ser_data = ~ser_data;
        #(20 * h) ser_enable = 1'b1;
        #200;
    endtask

    // Clock pulses with enable high, as traffic for another device.
    task automatic stray(input int n);
        for (int i = 0; i < n; i++) begin
            ser_data = ~ser_data;
            #80 ser_clk = 1'b1;
            #80 ser_clk = 1'b0;
        end
    endtask
endmodule

// ==== test_tone_volume_serial_decoder.sv ====
// Purpose: Self-checking bench for the serial tone and volume decoder.
// Assumes: Commit order equals send order; one strobe per accepted frame.
// Notes:   A strobe with no note queued counts as a mismatch.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; \
    $display("mismatch %s exp %h got %h", nm, e, g); end end

module test_tone_volume_serial_decoder;
    logic        clk_sys;
    logic        rst_n;
    logic        ser_clk;
    logic        ser_data;
    logic        ser_enable;
    logic [5:0]  volume_level_r;
    logic [4:0]  fader_rf_r;
    logic [4:0]  fader_lf_r;
    logic [4:0]  fader_rr_r;
    logic [4:0]  fader_lr_r;
    logic [3:0]  treble_level_r;
    logic [3:0]  bass_level_r;
    logic [2:0]  input_sel_r;
    logic        cmd_strobe_r;
    logic [36:0] seen;
    logic [36:0] exp_q[$];
    logic [36:0] want;
    logic [5:0]  e_vol;
    logic [4:0]  e_fad[4];
    logic [3:0]  e_tr;
    logic [3:0]  e_bs;
    logic [2:0]  e_in;
    logic [31:0] rng;
    logic [31:0] r;
    logic [5:0]  tops[8];
    int          fails;
    int          n_checks;

    tone_volume_serial_decoder uut (
        .clk_sys(clk_sys), .rst_n(rst_n), .ser_clk(ser_clk),
        .ser_data(ser_data), .ser_enable(ser_enable),
        .volume_level_r(volume_level_r), .fader_rf_r(fader_rf_r),
        .fader_lf_r(fader_lf_r), .fader_rr_r(fader_rr_r),
        .fader_lr_r(fader_lr_r), .treble_level_r(treble_level_r),
        .bass_level_r(bass_level_r), .input_sel_r(input_sel_r),
        .cmd_strobe_r(cmd_strobe_r)
    );

    serial_ctl_model ctl (
        .clk_sys(clk_sys), .ser_clk(ser_clk), .ser_data(ser_data),
        .ser_enable(ser_enable)
    );

    // All settings in one word, faders in selector order 100 to 111.
    assign seen = {volume_level_r, fader_rf_r, fader_lf_r, fader_rr_r,
                   fader_lr_r, treble_level_r, bass_level_r, input_sel_r};

    // Expected settings packed the same way.
    function automatic logic [36:0] state();
        return {e_vol, e_fad[0], e_fad[1], e_fad[2], e_fad[3],
                e_tr, e_bs, e_in};
    endfunction

    // Xorshift source; fixed start keeps runs repeatable.
    function automatic logic [31:0] next_rand();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction

    // A listed code for the selector, with random don't-care bits.
    function automatic logic [5:0] legal(input logic [2:0] sel);
        logic [31:0] v;
        v = next_rand();
        case (sel)
            3'h0: return {v[5:4], 1'b0, 3'(v[15:8] % 5)}; // Inputs.
            3'h1, 3'h2: return {v[5:4], 4'(v[15:8] % 13)}; // Tone.
            3'h3: return 6'(v[15:8] % 42); // Volume.
            default: return {v[5], 5'(v[15:8] % 22)}; // Faders.
        endcase
    endfunction

    // Builds a frame with k padding bits, notes the outcome, sends it.
    task automatic cmd(input logic [1:0] ad, input int k,
                       input logic [2:0] sel, input logic [5:0] st,
                       input int h);
        logic [23:0] f;
        f = {22'h000000, ad};
        f = (f << k) | 24'(next_rand() >> (32 - k)); // Padding.
        f = (f << 9) | {15'h0000, sel, st}; // Selector, then setting.
        if (ad == 2'h2) begin // Only address 10 selects.
            case (sel)
                3'h0: e_in = st[2:0];
                3'h1: e_bs = st[3:0];
                3'h2: e_tr = st[3:0];
                3'h3: e_vol = (st > 6'h28) ? 6'h28 : st;
                default: e_fad[sel - 3'h4] = (st[4:0] > 5'h14) ? 5'h14
                                                              : st[4:0];
            endcase
            exp_q.push_back(state());
        end
        ctl.send(f, 11 + k, h);
    endtask

    // Closing report, shared by the main sequence and the watchdog.
    task automatic test_done();
        if (fails == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // System clock, 50 MHz.
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    // Each commit strobe takes the oldest note; checked where values settle.
    always @(negedge clk_sys) begin
        if (cmd_strobe_r === 1'b1) begin
            if (exp_q.size() == 0) begin
                fails++;
                $display("mismatch strobe exp none got commit");
            end else begin
                // Popped once here; the macro reads its argument twice.
                want = exp_q.pop_front();
                `CHK("settings", want, seen);
            end
        end
    end

    // Cuts a hang short well inside the cycle budget.
    initial begin
        #1500000;
        fails++;
        test_done();
    end

    // Main sequence.
    initial begin
        rst_n = 1'b0;
        rng = 32'h101C;
        fails = 0;
        n_checks = 0;
        e_vol = 6'h00;
        e_fad = '{default: 5'h00};
        e_tr = 4'h6;
        e_bs = 4'h6;
        e_in = 3'h0;
        tops = '{6'h04, 6'h3C, 6'h0C, 6'h29, 6'h14, 6'h35, 6'h34, 6'h15};
        repeat (4) @(posedge clk_sys);
        #1 rst_n = 1'b1;
        `CHK("reset", state(), seen); // Minimum levels, flat tone.
        repeat (6) @(posedge clk_sys);
        // Every function at its top code, then at its bottom code.
        for (int s = 0; s < 8; s++) cmd(2'h2, 0, 3'(s), tops[s], 4);
        for (int s = 0; s < 8; s++) cmd(2'h2, 1, 3'(s), 6'h00, 4);
        // Foreign addresses, a short frame and stray clocks are all dropped.
        for (int a = 0; a < 4; a++)
            if (a != 2) cmd(2'(a), 0, 3'h3, 6'h14, 4);
        ctl.send(24'h0002FF, 10, 4); // Eight bits after address.
        ctl.stray(5); // Clocks with enable high.
        // Random legal commands with padding, at two link speeds.
        for (int i = 0; i < 60; i++) begin
            r = next_rand();
            cmd(2'h2, int'(r[2:0]), r[5:3], legal(r[5:3]), r[6] ? 12 : 4);
        end
        for (int i = 0; i < 200 && exp_q.size() > 0; i++) @(posedge clk_sys);
        if (exp_q.size() > 0) fails++;
        test_done();
    end
endmodule
